// *** hdl/admc_top.sv ***
// Converter mode, start-up timer and supply reset control
// Notes on behaviour
// - Reference buffer powered only in start-up/standby/converting
// - Auto-zero steps with modulator clock when enabled and reference selected, except in shutdown and scan wait
// - Supply monitors active except in full shutdown
// - Undervoltage holds reset, no commands, defaults
// - Leave reset 100 hclk cycles after both supplies good
// - Either supply falling re-enters reset at once
// - Chip select high pulse re-arms serial interface
// - No supply reset event in full shutdown
// - Mode 11 convert, 10 standby, 0x shutdown
// - Mode field shows request, not actual state
// - Mode field resets to shutdown
// - Shutdown to convert waits 256 modulator periods
// - Rewrite 11 restarts current single conversion
// - Mode reads 11 through whole scan cycle
// - Rewrite 11 restarts scan; delay if waiting
// - Result loads only complete conversions
// - End of conversion raises data ready flags
// - Result cleared only by reset or full reset
// - Standby holds converter reset, converts immediately
// - Shutdown immediate, later start needs full delay
// - Fast commands set each mode directly
// - Full shutdown command clears config word zero
// - Shutdown reloads start-up counter to 256
`timescale 1ns/1ps
module admc_top
  import admc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Pins from outside the clock domain
  input  wire logic        modulator_master_clock,
  input  wire logic        avdd_ok,
  input  wire logic        dvdd_ok,
  input  wire logic        cs_n,
  // Modulator sample on hclk
  input  wire logic [23:0] conv_sample,
  // Control outputs
  output logic             ref_buffer_on,
  output logic             autozero_strobe,
  output logic             serial_enable,
  output logic             por_monitor_enable,
  output logic             adc_held_reset,
  output logic             conv_active,
  output logic [1:0]       scan_entry
);
  admc_sync_if #(.W(SYNC_W)) sif ();
  admc_state_t state;
  logic [7:0]  configuration_word_zero;
  logic [7:0]  configuration_word_two;
  logic [23:0] conversion_result_register;
  logic        data_ready_flag;
  logic        irq_por;
  logic        full_shdn;
  logic        por_hold;
  logic [6:0]  por_cnt;
  logic        mclk_d;
  logic [8:0]  su_cnt;
  logic [7:0]  conv_cnt;
  logic [7:0]  addr_q;
  logic        wr_pend;
  logic        rd_pend;
  logic [31:0] rd_word;
  logic        mod_tick;
  logic        supplies_ok;
  logic        por_rel;
  logic        wr_go;
  logic        cfg0_wr;
  logic        cfg2_wr;
  logic        fc_wr;
  logic        irq_wr;
  logic        full_rst;
  logic        soft_clr;
  logic        set_conv;
  logic        eoc;
  logic [1:0]  mode;

  // Pin filtering
  assign sif.raw = {cs_n, dvdd_ok, avdd_ok, modulator_master_clock};
  admc_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (sif)
  );

  // Modulator clock rising edge found on hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mclk_d <= 1'b0;
    end else begin
      mclk_d <= sif.clean[0];
    end
  end
  assign mod_tick    = sif.clean[0] & ~mclk_d;
  assign supplies_ok = sif.clean[1] & sif.clean[2];

  // Supply reset: held while either supply is low, except in full shutdown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_hold <= 1'b1;
      por_cnt  <= 7'h00;
    end else if (!full_shdn) begin
      if (!supplies_ok) begin
        por_hold <= 1'b1;
        por_cnt  <= 7'h00;
      end else if (por_hold) begin
        if (por_rel) begin
          por_hold <= 1'b0;
        end else begin
          por_cnt <= por_cnt + 7'h01;
        end
      end
    end
  end
  assign por_rel = por_hold & supplies_ok & ~full_shdn &
                   (por_cnt == POR_CYCLES - 7'h01);

  // Serial interface enable waits for chip select high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_enable <= 1'b0;
    end else if (por_hold) begin
      serial_enable <= 1'b0;
    end else if (sif.clean[3]) begin
      serial_enable <= 1'b1;
    end
  end

  // AHB-Lite address and data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      addr_q    <= ADDR_NONE;
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      if (rd_pend) begin
        hrdata    <= rd_word;
        hreadyout <= 1'b1;
        rd_pend   <= 1'b0;
      end else if (hsel && hready && htrans[1]) begin
        addr_q    <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0]
                                                  : ADDR_NONE;
        wr_pend   <= hwrite;
        rd_pend   <= ~hwrite;
        hreadyout <= hwrite;
      end
    end
  end
  assign hresp = 1'b0;

  // Write strobes; ignored while held in supply reset
  assign wr_go    = wr_pend & serial_enable & ~por_hold;
  assign cfg0_wr  = wr_go && addr_q == ADDR_CFG0;
  assign cfg2_wr  = wr_go && addr_q == ADDR_CFG2;
  assign fc_wr    = wr_go && addr_q == ADDR_FCMD;
  assign irq_wr   = wr_go && addr_q == ADDR_IRQ;
  assign full_rst = fc_wr && hwdata[3:0] == FC_FULL_RST;
  assign soft_clr = por_hold | full_rst;
  assign set_conv = (cfg0_wr && admc_mode_conv(hwdata[1:0])) ||
                    (fc_wr && hwdata[3:0] == FC_CONV);
  assign mode     = configuration_word_zero[CFG0_MODE_LO +: 2];

  // Configuration word zero with fast command effects
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      configuration_word_zero <= CFG0_RST;
    end else if (soft_clr) begin
      configuration_word_zero <= CFG0_RST;
    end else if (fc_wr && hwdata[3:0] == FC_FULL_SHDN) begin
      configuration_word_zero <= 8'h00;
    end else if (cfg0_wr) begin
      configuration_word_zero <= hwdata[7:0];
    end else if (fc_wr && hwdata[3:0] == FC_CONV) begin
      configuration_word_zero[CFG0_MODE_LO +: 2] <= MODE_CONV;
    end else if (fc_wr && hwdata[3:0] == FC_STBY) begin
      configuration_word_zero[CFG0_MODE_LO +: 2] <= MODE_STBY;
    end else if (fc_wr && hwdata[3:0] == FC_SHDN) begin
      configuration_word_zero[CFG0_MODE_LO +: 2] <= MODE_SHDN;
    end
  end

  // Configuration word two holds the auto-zero enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      configuration_word_two <= CFG2_RST;
    end else if (soft_clr) begin
      configuration_word_two <= CFG2_RST;
    end else if (cfg2_wr) begin
      configuration_word_two <= hwdata[7:0];
    end
  end

  // Full shutdown entered by command, left by a mode command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_shdn <= 1'b0;
    end else if (soft_clr) begin
      full_shdn <= 1'b0;
    end else if (fc_wr && hwdata[3:0] == FC_FULL_SHDN) begin
      full_shdn <= 1'b1;
    end else if (fc_wr && (hwdata[3:0] == FC_CONV ||
                 hwdata[3:0] == FC_STBY || hwdata[3:0] == FC_SHDN)) begin
      full_shdn <= 1'b0;
    end
  end

  // End of a fully completed conversion
  assign eoc = state == ST_CONV && admc_mode_conv(mode) && !set_conv &&
               mod_tick && conv_cnt == CONV_PERIODS - 8'h01;

  // Operating state, start-up timer and conversion sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= ST_SHDN;
      su_cnt     <= STARTUP_PERIODS;
      conv_cnt   <= 8'h00;
      scan_entry <= 2'h0;
    end else if (soft_clr) begin
      state      <= ST_SHDN;
      su_cnt     <= STARTUP_PERIODS;
      conv_cnt   <= 8'h00;
      scan_entry <= 2'h0;
    end else if (!admc_mode_run(mode)) begin
      state  <= ST_SHDN;
      su_cnt <= STARTUP_PERIODS;
    end else begin
      unique case (state)
        ST_SHDN: begin
          state  <= ST_START;
          su_cnt <= STARTUP_PERIODS;
        end
        ST_START: begin
          if (mod_tick) begin
            if (su_cnt == 9'h001) begin
              state      <= mode[0] ? ST_CONV : ST_STBY;
              conv_cnt   <= 8'h00;
              scan_entry <= 2'h0;
            end else begin
              su_cnt <= su_cnt - 9'h001;
            end
          end
        end
        ST_STBY: begin
          if (mode[0]) begin
            state      <= ST_CONV;
            conv_cnt   <= 8'h00;
            scan_entry <= 2'h0;
          end
        end
        ST_CONV: begin
          if (!mode[0]) begin
            state <= ST_STBY;
          end else if (set_conv) begin
            conv_cnt   <= 8'h00;
            scan_entry <= 2'h0;
          end else if (eoc) begin
            conv_cnt <= 8'h00;
            if (configuration_word_zero[CFG0_SCAN]) begin
              if (scan_entry == SCAN_LAST) begin
                state      <= ST_SCAN_WAIT;
                scan_entry <= 2'h0;
              end else begin
                scan_entry <= scan_entry + 2'h1;
              end
            end
          end else if (mod_tick) begin
            conv_cnt <= conv_cnt + 8'h01;
          end
        end
        ST_SCAN_WAIT: begin
          if (set_conv || (mod_tick && conv_cnt == SCAN_DELAY - 8'h01))
          begin
            state    <= ST_START;
            su_cnt   <= STARTUP_PERIODS;
            conv_cnt <= 8'h00;
          end else if (mod_tick) begin
            conv_cnt <= conv_cnt + 8'h01;
          end
        end
      endcase
    end
  end

  // Result register keeps the last complete conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_result_register <= 24'h00_0000;
    end else if (soft_clr) begin
      conversion_result_register <= 24'h00_0000;
    end else if (eoc) begin
      conversion_result_register <= conv_sample;
    end
  end

  // Sticky flags; a new event wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ready_flag <= 1'b0;
      irq_por         <= 1'b0;
    end else begin
      if (eoc) begin
        data_ready_flag <= 1'b1;
      end else if (soft_clr || (irq_wr && hwdata[IRQ_DR])) begin
        data_ready_flag <= 1'b0;
      end
      if (por_rel) begin
        irq_por <= 1'b1;
      end else if (full_rst || (irq_wr && hwdata[IRQ_POR])) begin
        irq_por <= 1'b0;
      end
    end
  end

  // Register read; configuration word zero mode field reads the request
  always_comb begin
    rd_word = 32'h0000_0000;
    case (addr_q)
      ADDR_CFG0: rd_word[7:0] = configuration_word_zero;
      ADDR_CFG2: rd_word[7:0] = configuration_word_two;
      ADDR_STAT: begin
        rd_word[STAT_DR]            = data_ready_flag;
        rd_word[STAT_SER]           = serial_enable;
        rd_word[STAT_FSHDN]         = full_shdn;
        rd_word[STAT_STATE_LO +: 3] = 3'(state);
      end
      ADDR_IRQ: begin
        rd_word[IRQ_DR]  = data_ready_flag;
        rd_word[IRQ_POR] = irq_por;
      end
      ADDR_RES: rd_word[23:0] = conversion_result_register;
      default: rd_word = 32'h0000_0000;
    endcase
    if (por_hold) begin
      rd_word = 32'h0000_0000;
    end
  end

  // Analog control outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_buffer_on      <= 1'b0;
      autozero_strobe    <= 1'b0;
      por_monitor_enable <= 1'b1;
      adc_held_reset     <= 1'b0;
      conv_active        <= 1'b0;
    end else begin
      ref_buffer_on <= configuration_word_zero[CFG0_REFSEL] &&
                       (state == ST_START || state == ST_STBY ||
                        state == ST_CONV);
      autozero_strobe <= configuration_word_two[CFG2_AZ] && mod_tick &&
                         configuration_word_zero[CFG0_REFSEL] &&
                         state != ST_SHDN && state != ST_SCAN_WAIT;
      por_monitor_enable <= ~full_shdn;
      adc_held_reset     <= state == ST_STBY;
      conv_active        <= state == ST_CONV;
    end
  end

  // Helper: modulator edges counted in start-up
  logic [8:0] st_ticks;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ticks <= 9'h000;
    end else if (state != ST_START) begin
      st_ticks <= 9'h000;
    end else if (mod_tick) begin
      st_ticks <= st_ticks + 9'h001;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_startup_len: assert property (
    state == ST_START ##1 (state == ST_CONV || state == ST_STBY)
    |-> $past(st_ticks) == 9'h0ff)
    else $error("start-up did not last 256 modulator periods");
  a_shdn_now: assert property (
    (state == ST_CONV || state == ST_STBY) && !admc_mode_run(mode)
    |=> state == ST_SHDN && su_cnt == STARTUP_PERIODS)
    else $error("shutdown not immediate");
  a_conv_restart: assert property (
    state == ST_CONV && set_conv && admc_mode_conv(mode) && !soft_clr
    |=> conv_cnt == 8'h00 && scan_entry == 2'h0)
    else $error("rewrite did not restart conversion");
  a_result_eoc: assert property (
    !$stable(conversion_result_register) |-> $past(eoc || soft_clr))
    else $error("result changed without end of conversion");
  a_result_clear: assert property (
    soft_clr |=> conversion_result_register == 24'h00_0000)
    else $error("result not cleared");
  a_dr_event: assert property (
    eoc |=> data_ready_flag)
    else $error("data ready not raised");
  a_dr_read: assert property (
    rd_pend && (addr_q == ADDR_STAT || addr_q == ADDR_IRQ) &&
    data_ready_flag && !por_hold |=> hrdata[STAT_DR])
    else $error("data ready not shown on read");
  a_por_enter: assert property (
    !supplies_ok && !full_shdn |=> por_hold ##1 !serial_enable)
    else $error("supply reset not entered");
  a_por_quiet: assert property (
    full_shdn && !por_hold |=> !por_hold)
    else $error("supply reset in full shutdown");
  a_mon_off: assert property (
    full_shdn |=> !por_monitor_enable)
    else $error("monitor enabled in full shutdown");
  a_refbuf_off: assert property (
    state == ST_SHDN |=> !ref_buffer_on)
    else $error("reference buffer on in shutdown");
  a_az_strobe: assert property (
    autozero_strobe |-> $past(mod_tick && configuration_word_two[CFG2_AZ]))
    else $error("auto-zero strobe without enable");
  a_full_shdn_cfg: assert property (
    fc_wr && hwdata[3:0] == FC_FULL_SHDN && !soft_clr
    |=> configuration_word_zero == 8'h00 && full_shdn)
    else $error("full shutdown did not clear configuration");

  c_reach_conv: cover property (state == ST_START ##1 state == ST_CONV);
  c_eoc: cover property (eoc);
  c_scan_wait: cover property (state == ST_SCAN_WAIT ##1 state == ST_START);
  c_por_rel: cover property (por_rel);
endmodule

// *** hdl/admc_pkg.sv ***
// Constants, types and decoding shared by the converter control block
package admc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG2 = 8'h04;
  localparam logic [7:0] ADDR_FCMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ  = 8'h10;
  localparam logic [7:0] ADDR_RES  = 8'h14;
  localparam logic [7:0] ADDR_NONE = 8'hff;
  // Field positions
  localparam int CFG0_MODE_LO  = 0;
  localparam int CFG0_REFSEL   = 2;
  localparam int CFG0_SCAN     = 3;
  localparam int CFG2_AZ       = 0;
  localparam int STAT_DR       = 0;
  localparam int STAT_SER      = 1;
  localparam int STAT_FSHDN    = 2;
  localparam int STAT_STATE_LO = 4;
  localparam int IRQ_DR        = 0;
  localparam int IRQ_POR       = 1;
  // Values after reset
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h01;
  // Mode field and fast command codes
  localparam logic [1:0] MODE_CONV    = 2'h3;
  localparam logic [1:0] MODE_STBY    = 2'h2;
  localparam logic [1:0] MODE_SHDN    = 2'h0;
  localparam logic [3:0] FC_CONV      = 4'ha;
  localparam logic [3:0] FC_STBY      = 4'hb;
  localparam logic [3:0] FC_SHDN      = 4'hc;
  localparam logic [3:0] FC_FULL_SHDN = 4'hd;
  localparam logic [3:0] FC_FULL_RST  = 4'he;
  // Counts in modulator clock periods, and the last scan entry
  localparam logic [8:0] STARTUP_PERIODS = 9'h100;
  localparam logic [7:0] CONV_PERIODS    = 8'h40;
  localparam logic [7:0] SCAN_DELAY      = 8'h20;
  localparam logic [1:0] SCAN_LAST       = 2'h3;
  // Supply detection time
  localparam int T_POR_NS = 1000;
  localparam int CLK_NS   = 10;
  localparam logic [6:0] POR_CYCLES =
    7'((T_POR_NS + CLK_NS - 1) / CLK_NS);
  // Synchroniser width: modulator clock, two supplies, chip select
  localparam int SYNC_W = 4;

  typedef enum logic [2:0] {
    ST_SHDN, ST_START, ST_STBY, ST_CONV, ST_SCAN_WAIT
  } admc_state_t;

  // Mode field: converter runs when the high bit is set
  function automatic logic admc_mode_run(input logic [1:0] m);
    return m[1];
  endfunction

  function automatic logic admc_mode_conv(input logic [1:0] m);
    return m == MODE_CONV;
  endfunction
endpackage

// *** hdl/admc_sync_if.sv ***
// Raw and filtered pin levels between the synchroniser and the core
`timescale 1ns/1ps
interface admc_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// *** hdl/admc_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module admc_sync
  import admc_pkg::*;
(
  // Clock and reset
  input wire logic   hclk,
  input wire logic   hresetn,
  // Pin levels
  admc_sync_if.filt  sif
);
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic c;
      // Output follows only when stages two and three agree
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          c  <= 1'b0;
        end else begin
          s1 <= sif.raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            c <= s3;
          end
        end
      end
      assign sif.clean[i] = c;
    end
  endgenerate
endmodule

// *** sim/admc_far_side.sv ***
// Far-side model: supply monitors, modulator clock, chip select, sample
`timescale 1ns/1ps
module admc_far_side (
  // Levels asked for by the bench
  input  wire logic        avdd_req,
  input  wire logic        dvdd_req,
  input  wire logic        cs_req_n,
  input  wire logic [23:0] sample_req,
  // Pins toward the block
  output logic             modulator_master_clock,
  output logic             avdd_ok,
  output logic             dvdd_ok,
  output logic             cs_n,
  output logic [23:0]      conv_sample
);
  // Free-running modulator clock, 160 ns period
  initial begin
    modulator_master_clock = 1'b0;
    forever #80 modulator_master_clock = ~modulator_master_clock;
  end
  // Comparators settle a few ns after the supply moves
  assign #3 avdd_ok = avdd_req;
  assign #3 dvdd_ok = dvdd_req;
  // Host pulses chip select high to re-arm the port
  assign #2 cs_n = cs_req_n;
  assign conv_sample = sample_req;
endmodule

// *** sim/tb_adc_mode_and_por_control.sv ***
// Self-checking bench for the converter mode and supply reset block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_adc_mode_and_por_control;
  import admc_pkg::*;
  typedef struct packed {
    logic        w;
    logic [31:0] a;
    logic [31:0] d;
  } admc_row_t;
  logic        hclk       = 1'b0;
  logic        hresetn    = 1'b0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [2:0]  hsize      = 3'h2;
  logic [31:0] hwdata     = 32'h0;
  logic        avdd_req   = 1'b1;
  logic        dvdd_req   = 1'b1;
  logic        cs_req_n   = 1'b1;
  logic [23:0] sample_req = 24'h123456;
  logic        hreadyout, hresp, mclk, avdd_ok, dvdd_ok, cs_n;
  logic [31:0] hrdata;
  logic [23:0] conv_sample;
  logic        ref_buffer_on, autozero_strobe, serial_enable;
  logic        por_monitor_enable, adc_held_reset, conv_active;
  logic [1:0]  scan_entry;
  int          n_errors = 0;
  int          compares = 0;
  // Register cases: write, or read and compare
  admc_row_t rows [12] = '{
    '{1'b0, 32'h00, 32'h00}, '{1'b0, 32'h04, 32'h01},
    '{1'b0, 32'h14, 32'h00}, '{1'b0, 32'h0c, 32'h02},
    '{1'b0, 32'h10, 32'h02}, '{1'b1, 32'h10, 32'h02},
    '{1'b0, 32'h10, 32'h00}, '{1'b1, 32'h00, 32'ha4},
    '{1'b0, 32'h00, 32'ha4}, '{1'b0, 32'h08, 32'h00},
    '{1'b0, 32'h100, 32'h00}, '{1'b1, 32'h00, 32'h00}};
  logic [3:0] fc [4] = '{FC_CONV, FC_SHDN, FC_STBY, FC_SHDN};
  logic [2:0] st [4] = '{3'h1, 3'h0, 3'h1, 3'h0};

  admc_top u_admc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .modulator_master_clock(mclk), .avdd_ok(avdd_ok),
    .dvdd_ok(dvdd_ok), .cs_n(cs_n), .conv_sample(conv_sample),
    .ref_buffer_on(ref_buffer_on), .autozero_strobe(autozero_strobe),
    .serial_enable(serial_enable), .por_monitor_enable(por_monitor_enable),
    .adc_held_reset(adc_held_reset), .conv_active(conv_active),
    .scan_entry(scan_entry));
  admc_far_side u_admc_far_side (
    .avdd_req(avdd_req), .dvdd_req(dvdd_req), .cs_req_n(cs_req_n),
    .sample_req(sample_req), .modulator_master_clock(mclk),
    .avdd_ok(avdd_ok), .dvdd_ok(dvdd_ok), .cs_n(cs_n),
    .conv_sample(conv_sample));

  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One AHB single transfer; both phases wait for ready
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin
        n_errors++;
        end_of_test();
      end
      if (p == 0) begin
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
      end
    end
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask
  // Count auto-zero pulses over ten modulator periods
  task automatic az(input int e);
    int na;
    na = 0;
    repeat (160) begin
      @(posedge hclk);
      na += int'(autozero_strobe);
    end
    `CHK(na, e)
  endtask
  // Poll the flag register until a result is flagged
  task automatic wait_dr();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, 32'h10, 32'h0, q);
      n++;
    end while (q[IRQ_DR] !== 1'b1 && n < 1000);
    `CHK(q[IRQ_DR], 1'b1)
  endtask
  task automatic done(input string s);
    $display("Test %0s done", s);
  endtask

  initial begin
    forever #5 hclk = ~hclk;
  end
  initial begin
    cyc(16);
    hresetn <= 1'b1;
    cyc(140);
    `CHK(serial_enable, 1'b1)
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        chk(rows[i].a, rows[i].d);
      end
    end
    done("registers");
    // Start-up from shutdown into standby
    wr(32'h00, 32'h06);
    cyc(8);
    `CHK(ref_buffer_on, 1'b1)
    chk(32'h0c, 32'h12);
    cyc(16 * 240);
    `CHK(adc_held_reset, 1'b0)
    cyc(16 * 24);
    `CHK(adc_held_reset, 1'b1)
    az(10);
    wr(32'h04, 32'h0);
    cyc(2);
    az(0);
    wr(32'h04, 32'h1);
    done("start-up");
    // Conversions, restart and result holding
    wr(32'h00, 32'h07);
    cyc(8);
    `CHK(conv_active, 1'b1)
    wait_dr();
    chk(32'h14, 32'h123456);
    sample_req <= 24'hfedcba;
    cyc(16 * 40);
    wr(32'h00, 32'h07);
    wr(32'h10, 32'h1);
    cyc(16 * 56);
    chk(32'h10, 32'h0);
    chk(32'h14, 32'h123456);
    wait_dr();
    chk(32'h14, 32'hfedcba);
    wr(32'h00, 32'h06);
    cyc(8);
    `CHK({conv_active, adc_held_reset}, 2'b01)
    wr(32'h00, 32'h05);
    cyc(8);
    `CHK({ref_buffer_on, adc_held_reset}, 2'b00)
    wr(32'h00, 32'h07);
    cyc(16 * 200);
    `CHK(conv_active, 1'b0)
    wr(32'h08, {28'h0, FC_FULL_RST});
    chk(32'h14, 32'h0);
    done("conversion");
    // Fast commands and full shutdown
    foreach (fc[i]) begin
      wr(32'h08, {28'h0, fc[i]});
      chk(32'h0c, {25'h0, st[i], 4'h2});
    end
    wr(32'h00, 32'h26);
    wr(32'h08, {28'h0, FC_FULL_SHDN});
    chk(32'h00, 32'h0);
    cyc(4);
    `CHK(por_monitor_enable, 1'b0)
    avdd_req <= 1'b0;
    cyc(30);
    `CHK(serial_enable, 1'b1)
    avdd_req <= 1'b1;
    cyc(130);
    chk(32'h10, 32'h0);
    wr(32'h08, {28'h0, FC_SHDN});
    cyc(4);
    `CHK(por_monitor_enable, 1'b1)
    done("fast commands");
    // Sequencer scan: entries advance, mode reads 11, rewrite restarts
    wr(32'h00, 32'h0b);
    cyc(16 * 416);
    `CHK(scan_entry, 2'h2)
    chk(32'h00, 32'h0b);
    wr(32'h00, 32'h0b);
    cyc(8);
    `CHK(scan_entry, 2'h0)
    cyc(16 * 272);
    chk(32'h0c, 32'h43);
    chk(32'h00, 32'h0b);
    wr(32'h00, 32'h0b);
    cyc(8);
    chk(32'h0c, 32'h13);
    done("scan");
    // Supply loss and return
    wr(32'h00, 32'h24);
    dvdd_req <= 1'b0;
    cyc(10);
    `CHK(serial_enable, 1'b0)
    dvdd_req <= 1'b1;
    cyc(90);
    `CHK(serial_enable, 1'b0)
    cyc(30);
    `CHK(serial_enable, 1'b1)
    chk(32'h00, 32'h0);
    chk(32'h10, 32'h2);
    cs_req_n <= 1'b0;
    avdd_req <= 1'b0;
    cyc(10);
    avdd_req <= 1'b1;
    cyc(130);
    `CHK(serial_enable, 1'b0)
    cs_req_n <= 1'b1;
    cyc(10);
    `CHK(serial_enable, 1'b1)
    done("supply");
    end_of_test();
  end
endmodule
